/* File: bench/tb.sv */
`timescale 1ns/1ps
`include "tcps_map.svh"
module tb;
  logic        clk_sys, rst_n, input_polarity_strap, control_mode_strap;
  logic        psel, penable, pwrite, pready, pslverr, er;
  logic [2:0]  conn, flip, both, ea, eb, phy_a_en, phy_b_en;
  logic [2:0]  attach_in, orientation_sel_in, orient_a_attach_in, orient_b_attach_in;
  logic [5:0]  junk;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, rd;
  int          errors, check_count;
  int          cycles = 0;
  integer      seed;
  tcps_top dut_u (
    .clk_sys              (clk_sys),
    .rst_n                (rst_n),
    .attach_in            (attach_in),
    .orientation_sel_in   (orientation_sel_in),
    .orient_a_attach_in   (orient_a_attach_in),
    .orient_b_attach_in   (orient_b_attach_in),
    .input_polarity_strap (input_polarity_strap),
    .control_mode_strap   (control_mode_strap),
    .paddr                (paddr),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .pwdata               (pwdata),
    .pstrb                (pstrb),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .phy_a_en             (phy_a_en),
    .phy_b_en             (phy_b_en)
  );
  tcps_det_model det_u (
    .clk_sys              (clk_sys),
    .input_polarity_strap (input_polarity_strap),
    .control_mode_strap   (control_mode_strap),
    .conn                 (conn),
    .flip                 (flip),
    .both                 (both),
    .junk                 (junk),
    .attach_in            (attach_in),
    .orientation_sel_in   (orientation_sel_in),
    .orient_a_attach_in   (orient_a_attach_in),
    .orient_b_attach_in   (orient_b_attach_in)
  );
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic stop_test;
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    rst_n = 1'b0;
    {input_polarity_strap, control_mode_strap, conn, flip, both, junk} = '0;
    {paddr, psel, penable, pwrite, pwdata} = '0;
    pstrb = 4'hf;
    errors = 0;
    check_count = 0;
    seed = 32'h4f488638;
    for (int cfg = 0; cfg < 4; cfg++) begin
      @(posedge clk_sys);
      rst_n <= 1'b0;
      control_mode_strap <= cfg[0];
      input_polarity_strap <= cfg[1];
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (12) @(posedge clk_sys);
      for (int n = 0; n < 12; n++) begin
        conn <= 3'($random(seed));
        flip <= 3'($random(seed));
        both <= 3'($random(seed));
        junk <= 6'($random(seed));
        repeat (6) @(posedge clk_sys);
        ea = 3'h0;
        eb = 3'h0;
        for (int i = 0; i < 3; i++) begin
          if (conn[i] && (!flip[i] || (control_mode_strap && both[i]))) ea[i] = 1'b1;
          else if (conn[i]) eb[i] = 1'b1;
        end
        chk({26'h0, phy_b_en, phy_a_en}, {26'h0, eb, ea});
        apb(1'b0, `TCPS_OFF_STAT, 32'h0);
        chk(rd, {24'h1, input_polarity_strap, control_mode_strap, eb, ea});
      end
    end
    conn <= 3'h0;
    repeat (6) @(posedge clk_sys);
    apb(1'b1, `TCPS_OFF_CTRL, 32'h7);
    apb(1'b0, `TCPS_OFF_CTRL, 32'h0);
    chk(rd, 32'h7);
    apb(1'b1, `TCPS_OFF_CTRL, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    stop_test();
  end
endmodule : tb
bind tcps_top tcps_top_asserts chk_u (
  .clk_sys              (clk_sys),
  .rst_n                (rst_n),
  .attach_in            (attach_in),
  .orientation_sel_in   (orientation_sel_in),
  .orient_a_attach_in   (orient_a_attach_in),
  .orient_b_attach_in   (orient_b_attach_in),
  .input_polarity_strap (input_polarity_strap),
  .control_mode_strap   (control_mode_strap),
  .psel                 (psel),
  .penable              (penable),
  .pready               (pready),
  .pslverr              (pslverr),
  .phy_a_en             (phy_a_en),
  .phy_b_en             (phy_b_en)
);

/* File: bench/tcps_det_model.sv */
`timescale 1ns/1ps
module tcps_det_model (
  // clock and straps
  input  wire logic       clk_sys,
  input  wire logic       input_polarity_strap,
  input  wire logic       control_mode_strap,
  // commands
  input  wire logic [2:0] conn,
  input  wire logic [2:0] flip,
  input  wire logic [2:0] both,
  input  wire logic [5:0] junk,
  // detector pins
  output logic      [2:0] attach_in,
  output logic      [2:0] orientation_sel_in,
  output logic      [2:0] orient_a_attach_in,
  output logic      [2:0] orient_b_attach_in
);
  logic [2:0] p;
  assign p = {3{input_polarity_strap}};
  // unused group carries noise
  always @(posedge clk_sys) begin
    if (!control_mode_strap) begin
      attach_in <= conn ^ p;
      orientation_sel_in <= flip ^ p;
      {orient_a_attach_in, orient_b_attach_in} <= junk;
    end else begin
      orient_a_attach_in <= (conn & (~flip | both)) ^ p;
      orient_b_attach_in <= (conn & (flip | both)) ^ p;
      {attach_in, orientation_sel_in} <= junk;
    end
  end
endmodule : tcps_det_model

/* File: bench/tcps_top_asserts.sv */
`timescale 1ns/1ps
module tcps_top_asserts (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_n,
  // detector inputs and straps
  input wire logic [2:0] attach_in,
  input wire logic [2:0] orientation_sel_in,
  input wire logic [2:0] orient_a_attach_in,
  input wire logic [2:0] orient_b_attach_in,
  input wire logic       input_polarity_strap,
  input wire logic       control_mode_strap,
  // apb handshake
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // phy enables
  input wire logic [2:0] phy_a_en,
  input wire logic [2:0] phy_b_en
);
  logic [11:0] d1, d2, d3, n3;
  logic [3:0]  run_cnt;
  logic        run;
  // inputs delayed by the sync depth plus output flop
  always_ff @(posedge clk_sys) begin
    d1 <= {orient_b_attach_in, orient_a_attach_in, orientation_sel_in, attach_in};
    d2 <= d1;
    d3 <= d2;
    if (!rst_n) run_cnt <= 4'h0;
    else if (run_cnt != 4'hf) run_cnt <= run_cnt + 4'h1;
  end
  assign n3  = d3 ^ {12{input_polarity_strap}};
  assign run = run_cnt >= 4'ha;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_out_zero: assert property ($rose(rst_n) |-> (phy_a_en | phy_b_en) == 3'h0)
    else $error("phy enable set right after reset");
  a_never_both: assert property ((phy_a_en & phy_b_en) == 3'h0)
    else $error("both phy enables set on one port");
  a_m1_a_exact: assert property (run && !control_mode_strap |->
    phy_a_en == (n3[2:0] & ~n3[5:3])) else $error("mode 1 phy a mismatch");
  a_m1_b_exact: assert property (run && !control_mode_strap |->
    phy_b_en == (n3[2:0] & n3[5:3])) else $error("mode 1 phy b mismatch");
  a_m2_a_exact: assert property (run && control_mode_strap |->
    phy_a_en == n3[8:6]) else $error("mode 2 phy a mismatch");
  a_m2_b_exact: assert property (run && control_mode_strap |->
    phy_b_en == (n3[11:9] & ~n3[8:6])) else $error("mode 2 phy b mismatch");
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  a_ready_pulse: assert property (pready |=> !pready && !pslverr)
    else $error("apb answer held");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  c_phy_b: cover property (run && phy_b_en != 3'h0);
  c_phy_all_a: cover property (phy_a_en == 3'h7);
  c_err: cover property (pslverr);
endmodule : tcps_top_asserts

/* File: design/tcps_map.svh */
`ifndef TCPS_MAP_SVH
`define TCPS_MAP_SVH

// port count, synchroniser width and event counter width
`define TCPS_NPORT        3
`define TCPS_SYNC_W       14
`define TCPS_CNT_W        8

// last strap capture count after reset release; the capture window is this count plus one cycle
`define TCPS_STRAP_CYC    2'h3
`define TCPS_STRAP_CNT_W  2

// apb register byte offsets
`define TCPS_ADDR_W       8
`define TCPS_OFF_CTRL     8'h00
`define TCPS_OFF_STAT     8'h04
`define TCPS_OFF_RAW      8'h08
`define TCPS_OFF_CNT      8'h0c

// ctrl fields
`define TCPS_CTRL_DIS_LSB 0

// stat fields
`define TCPS_STAT_A_LSB   0
`define TCPS_STAT_B_LSB   3
`define TCPS_STAT_MODE    6
`define TCPS_STAT_POL     7
`define TCPS_STAT_RUN     8

// raw fields
`define TCPS_RAW_ATT_LSB  0
`define TCPS_RAW_ORI_LSB  3
`define TCPS_RAW_OA_LSB   6
`define TCPS_RAW_OB_LSB   9

// reset values
`define TCPS_RST_DIS      3'h0
`define TCPS_RST_POL      1'h0
`define TCPS_RST_MODE     1'h0

`endif

/* File: design/tcps_pkg.sv */
`include "tcps_map.svh"
package tcps_pkg;

  typedef enum logic [1:0] {
    TCPS_PH_LATCH = 2'h1,
    TCPS_PH_RUN   = 2'h2
  } tcps_phase_e;

  typedef struct packed {
    tcps_phase_e                               phase;
    logic [`TCPS_STRAP_CNT_W-1:0]              strap_cnt;
    logic                                      pol;
    logic                                      mode;
    logic [`TCPS_NPORT-1:0]                    dis;
    logic [`TCPS_NPORT-1:0]                    conn_prev;
    logic [`TCPS_NPORT*`TCPS_CNT_W-1:0]        cnt;
    logic [`TCPS_NPORT-1:0]                    phy_a;
    logic [`TCPS_NPORT-1:0]                    phy_b;
    logic                                      pready;
    logic                                      pslverr;
    logic [31:0]                               prdata;
  } tcps_state_s;

endpackage : tcps_pkg

/* File: design/tcps_sync.sv */
`timescale 1ns/1ps
module tcps_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // data
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s1;
  } tcps_sync_s;

  tcps_sync_s sync_reg;
  tcps_sync_s sync_next;

  // first stage feeds only the second stage
  always_comb begin
    sync_next    = sync_reg;
    sync_next.s1 = d_in;
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign q_out = sync_reg.s2;

endmodule : tcps_sync

/* File: design/tcps_top.sv */
`timescale 1ns/1ps
`include "tcps_map.svh"
// Contract
// - mode 2, B attach enables PHY B (the code enables PHY B only while A attach is low; A attach wins)
// - mode 2, no attach keeps PHY off
// - polarity strap low, inputs active high
// - polarity strap high, inputs active low
// - mode strap low selects mode 1
// - mode strap high selects mode 2
// - polarity strap defaults low when open
// - mode strap defaults to mode 1 when open
// - mode 1 attach switches port PHY on/off
// - mode 1 orientation 1 selects B, 0 A
// - mode 2, A attach enables PHY A
module tcps_top (
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  // mode 1 detector inputs
  input  wire logic [`TCPS_NPORT-1:0]      attach_in,
  input  wire logic [`TCPS_NPORT-1:0]      orientation_sel_in,
  // mode 2 detector inputs
  input  wire logic [`TCPS_NPORT-1:0]      orient_a_attach_in,
  input  wire logic [`TCPS_NPORT-1:0]      orient_b_attach_in,
  // straps
  input  wire logic                        input_polarity_strap,
  input  wire logic                        control_mode_strap,
  // apb slave
  input  wire logic [`TCPS_ADDR_W-1:0]     paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // phy enables
  output logic      [`TCPS_NPORT-1:0]      phy_a_en,
  output logic      [`TCPS_NPORT-1:0]      phy_b_en
);

  // inverts a port vector when inputs are active low
  function automatic logic [`TCPS_NPORT-1:0] tcps_norm(
    input logic [`TCPS_NPORT-1:0] raw,
    input logic                   pol
  );
    return raw ^ {`TCPS_NPORT{pol}};
  endfunction : tcps_norm

  // register address match
  function automatic logic tcps_hit(
    input logic [`TCPS_ADDR_W-1:0] addr,
    input logic [`TCPS_ADDR_W-1:0] off
  );
    return addr == off;
  endfunction : tcps_hit

  tcps_pkg::tcps_state_s st_reg;
  tcps_pkg::tcps_state_s st_next;

  logic [`TCPS_SYNC_W-1:0] sync_q;
  logic [`TCPS_NPORT-1:0]  att_s;
  logic [`TCPS_NPORT-1:0]  ori_s;
  logic [`TCPS_NPORT-1:0]  oa_s;
  logic [`TCPS_NPORT-1:0]  ob_s;
  logic                    pol_s;
  logic                    mode_s;
  logic [`TCPS_NPORT-1:0]  att_n;
  logic [`TCPS_NPORT-1:0]  ori_n;
  logic [`TCPS_NPORT-1:0]  oa_n;
  logic [`TCPS_NPORT-1:0]  ob_n;
  logic [`TCPS_NPORT-1:0]  req_a;
  logic [`TCPS_NPORT-1:0]  req_b;
  logic [`TCPS_NPORT-1:0]  conn;
  logic                    apb_acc;
  logic                    apb_wr;
  logic                    apb_map;

  // every detector input and strap crosses two flops
  tcps_sync #(
    .WIDTH (`TCPS_SYNC_W)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d_in    ({control_mode_strap, input_polarity_strap,
               orient_b_attach_in, orient_a_attach_in,
               orientation_sel_in, attach_in}),
    .q_out   (sync_q)
  );

  assign att_s  = sync_q[`TCPS_NPORT-1:0];
  assign ori_s  = sync_q[2*`TCPS_NPORT-1:`TCPS_NPORT];
  assign oa_s   = sync_q[3*`TCPS_NPORT-1:2*`TCPS_NPORT];
  assign ob_s   = sync_q[4*`TCPS_NPORT-1:3*`TCPS_NPORT];
  assign pol_s  = sync_q[4*`TCPS_NPORT];
  assign mode_s = sync_q[4*`TCPS_NPORT+1];

  // normalise to active high with the latched polarity
  assign att_n = tcps_norm(att_s, st_reg.pol);
  assign ori_n = tcps_norm(ori_s, st_reg.pol);
  assign oa_n  = tcps_norm(oa_s, st_reg.pol);
  assign ob_n  = tcps_norm(ob_s, st_reg.pol);

  // per-port phy request decode
  for (genvar p = 0; p < `TCPS_NPORT; p++) begin : g_port
    always_comb begin
      if (st_reg.mode) begin
        // mode 2 uses only the per-orientation attach inputs
        req_a[p] = oa_n[p];
        req_b[p] = ob_n[p] & ~oa_n[p];
      end else begin
        // mode 1 uses attach gated orientation
        req_a[p] = att_n[p] & ~ori_n[p];
        req_b[p] = att_n[p] & ori_n[p];
      end
    end
    assign conn[p] = req_a[p] | req_b[p];
  end

  // apb phases
  assign apb_acc = psel & penable & ~st_reg.pready;
  assign apb_wr  = psel & penable & pwrite & st_reg.pready & ~st_reg.pslverr;
  assign apb_map = tcps_hit(paddr, `TCPS_OFF_CTRL) | tcps_hit(paddr, `TCPS_OFF_STAT) |
                   tcps_hit(paddr, `TCPS_OFF_RAW) | tcps_hit(paddr, `TCPS_OFF_CNT);

  always_comb begin
    st_next = st_reg;

    // strap capture after reset release, then run
    case (st_reg.phase)
      tcps_pkg::TCPS_PH_LATCH: begin
        st_next.pol  = pol_s;
        st_next.mode = mode_s;
        if (st_reg.strap_cnt == `TCPS_STRAP_CYC) begin
          st_next.phase = tcps_pkg::TCPS_PH_RUN;
        end else begin
          st_next.strap_cnt = st_reg.strap_cnt + `TCPS_STRAP_CNT_W'(1);
        end
      end
      tcps_pkg::TCPS_PH_RUN: begin
        st_next.phase = tcps_pkg::TCPS_PH_RUN;
      end
      default: begin
        st_next.phase     = tcps_pkg::TCPS_PH_LATCH;
        st_next.strap_cnt = '0;
      end
    endcase

    // phy enables, held off until straps are settled
    if (st_reg.phase == tcps_pkg::TCPS_PH_RUN) begin
      st_next.phy_a     = req_a & ~st_reg.dis;
      st_next.phy_b     = req_b & ~st_reg.dis;
      st_next.conn_prev = conn;
    end else begin
      st_next.phy_a     = '0;
      st_next.phy_b     = '0;
      st_next.conn_prev = '0;
    end

    // register writes complete on the edge that sees pready high
    if (apb_wr && tcps_hit(paddr, `TCPS_OFF_CTRL) && pstrb[0]) begin
      st_next.dis = pwdata[`TCPS_CTRL_DIS_LSB +: `TCPS_NPORT];
    end

    // connect event counters, a new event in the clear cycle is counted after the clear, leaving 1
    for (int i = 0; i < `TCPS_NPORT; i++) begin
      if (apb_wr && tcps_hit(paddr, `TCPS_OFF_CNT) && pstrb[0] && pwdata[i]) begin
        st_next.cnt[i*`TCPS_CNT_W +: `TCPS_CNT_W] = '0;
      end
      if (st_reg.phase == tcps_pkg::TCPS_PH_RUN && conn[i] && !st_reg.conn_prev[i]) begin
        st_next.cnt[i*`TCPS_CNT_W +: `TCPS_CNT_W] =
          st_next.cnt[i*`TCPS_CNT_W +: `TCPS_CNT_W] + `TCPS_CNT_W'(1);
      end
    end

    // access phase: one wait state, then ready with data
    st_next.pready  = apb_acc;
    st_next.pslverr = 1'b0;
    st_next.prdata  = '0;
    if (apb_acc) begin
      st_next.pslverr = ~apb_map;
      if (!pwrite) begin
        if (tcps_hit(paddr, `TCPS_OFF_CTRL)) begin
          st_next.prdata[`TCPS_CTRL_DIS_LSB +: `TCPS_NPORT] = st_reg.dis;
        end
        if (tcps_hit(paddr, `TCPS_OFF_STAT)) begin
          st_next.prdata[`TCPS_STAT_A_LSB +: `TCPS_NPORT] = st_reg.phy_a;
          st_next.prdata[`TCPS_STAT_B_LSB +: `TCPS_NPORT] = st_reg.phy_b;
          st_next.prdata[`TCPS_STAT_MODE] = st_reg.mode;
          st_next.prdata[`TCPS_STAT_POL]  = st_reg.pol;
          st_next.prdata[`TCPS_STAT_RUN]  = (st_reg.phase == tcps_pkg::TCPS_PH_RUN);
        end
        if (tcps_hit(paddr, `TCPS_OFF_RAW)) begin
          st_next.prdata[`TCPS_RAW_ATT_LSB +: `TCPS_NPORT] = att_n;
          st_next.prdata[`TCPS_RAW_ORI_LSB +: `TCPS_NPORT] = ori_n;
          st_next.prdata[`TCPS_RAW_OA_LSB +: `TCPS_NPORT]  = oa_n;
          st_next.prdata[`TCPS_RAW_OB_LSB +: `TCPS_NPORT]  = ob_n;
        end
        if (tcps_hit(paddr, `TCPS_OFF_CNT)) begin
          st_next.prdata[`TCPS_NPORT*`TCPS_CNT_W-1:0] = st_reg.cnt;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_reg           <= '0;
      st_reg.phase     <= tcps_pkg::TCPS_PH_LATCH;
      st_reg.pol       <= `TCPS_RST_POL;
      st_reg.mode      <= `TCPS_RST_MODE;
      st_reg.dis       <= `TCPS_RST_DIS;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops
  assign prdata   = st_reg.prdata;
  assign pready   = st_reg.pready;
  assign pslverr  = st_reg.pslverr;
  assign phy_a_en = st_reg.phy_a;
  assign phy_b_en = st_reg.phy_b;

endmodule : tcps_top
